// file: shared/pla_pkg.sv
package pla_pkg;
    typedef logic [4:0] pla_addr_t;
    typedef logic [15:0] pla_word_t;
    typedef logic [7:0] pla_byte_t;

    localparam pla_addr_t PLA_ADDR_STATUS = 5'h11;
    localparam pla_addr_t PLA_ADDR_AUX = 5'h12;
    localparam pla_addr_t PLA_ADDR_LED = 5'h13;
    localparam pla_addr_t PLA_ADDR_REDUCED_INDICATOR_MODE_SEL = 5'h1a;

    localparam int PLA_STATUS_LOOP_BIT = 7;
    localparam int PLA_AUX_LOOP_BIT = 5;
    localparam int PLA_AUX_REV_BIT = 4;
    localparam int PLA_AUX_JAB_BIT = 0;
    localparam int PLA_LED_FIELD_LSB = 6;
    localparam int PLA_LED_REDUCED_BIT = 5;
    localparam int PLA_REDUCED_INDICATOR_MODE_SEL_BIT = 0;
    localparam int PLA_NUM_LEDS = 5;

    localparam logic PLA_AUX_BIT_RESET = 1'b0;
    localparam pla_word_t PLA_LED_RESET = 16'h0000;
    localparam logic PLA_REDUCED_INDICATOR_MODE_SEL_RESET = 1'b0;

    typedef enum logic [1:0] {
        PLA_MODE_NORMAL = 2'h0,
        PLA_MODE_OFF = 2'h1,
        PLA_MODE_BLINK = 2'h2,
        PLA_MODE_ON = 2'h3
    } pla_mode_t;

    localparam int PLA_CLK_HZ = 25000000;
    localparam int PLA_BLINK_PERIOD_MS = 750;
    localparam int PLA_BLINK_HALF_CYCLES = PLA_CLK_HZ / 1000 * PLA_BLINK_PERIOD_MS / 2;

    function automatic pla_byte_t pla_rev8(input pla_byte_t d);
        pla_byte_t r;
        for (int i = 0; i < 8; i++) begin
            r[i] = d[7 - i];
        end
        return r;
    endfunction : pla_rev8
endpackage : pla_pkg

// file: shared/pla_blink_if.sv
`timescale 1ns/1ps
interface pla_blink_if;
    logic blink;
    modport gen (output blink);
    modport use_side (input blink);
endinterface : pla_blink_if

// file: logic/pla_blink_gen.sv
`timescale 1ns/1ps
module pla_blink_gen #(
    parameter int HALF_CYCLES = pla_pkg::PLA_BLINK_HALF_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    pla_blink_if.gen blinkBus
);
    import pla_pkg::*;

    localparam int CW = $clog2(HALF_CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic blink;
    } pla_blink_state_t;

    pla_blink_state_t st;
    pla_blink_state_t next_st;

    // The level flips once per half period, giving a full blink period of 750 ms.
    always_comb begin
        next_st = st;
        if (st.cnt == LAST) begin
            next_st.cnt = '0;
            next_st.blink = ~st.blink;
        end else begin
            next_st.cnt = st.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign blinkBus.blink = st.blink;

    chk_blink_period: assert property (
        @(posedge clk_sys) disable iff (!rst_b)
        (st.blink != $past(st.blink)) |-> ($past(st.cnt) == LAST && st.cnt == '0))
        else $error("Blink level changed away from the end of a half period.");
endmodule : pla_blink_gen

// file: logic/pla_led_aux_top.sv
`timescale 1ns/1ps
module pla_led_aux_top #(
    parameter int BLINK_HALF_CYCLES = pla_pkg::PLA_BLINK_HALF_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire pla_pkg::pla_addr_t mgmtAddr,
    input wire pla_pkg::pla_word_t mgmtWrData,
    input wire logic mgmtWrEn,
    input wire logic mgmtRdEn,
    output logic [15:0] mgmtRdData,
    output logic mgmtRdValid,
    input wire pla_pkg::pla_byte_t macTxd,
    input wire logic macTxEn,
    input wire logic macTxEr,
    output logic [7:0] macRxd,
    output logic macRxDv,
    output logic macRxEr,
    output logic [7:0] lineTxd,
    output logic lineTxEn,
    output logic lineTxEr,
    input wire pla_pkg::pla_byte_t lineRxd,
    input wire logic lineRxDv,
    input wire logic lineRxEr,
    input wire logic jabberDetect,
    input wire logic mode10,
    output logic jabberActive,
    input wire logic link10,
    input wire logic link100,
    input wire logic link1000,
    input wire logic fullDuplex,
    input wire logic txActive,
    input wire logic rxActive,
    input wire logic idleError,
    output logic ledAct,
    output logic ledLink10,
    output logic ledLink100,
    output logic ledLink1000,
    output logic ledDuplex
);
    import pla_pkg::*;

    typedef struct packed {
        logic loopOn;
        logic revOn;
        logic jabDis;
        pla_word_t ledCtrl;
        logic rledSel;
        pla_word_t rdData;
        logic rdValid;
        logic [PLA_NUM_LEDS-1:0] led;
        pla_byte_t rxd;
        logic rxDv;
        logic rxEr;
        pla_byte_t txd;
        logic txEn;
        logic txEr;
        logic jabber;
    } pla_top_state_t;

    pla_top_state_t st;
    pla_top_state_t next_st;

    pla_blink_if blinkBus();

    pla_blink_gen #(
        .HALF_CYCLES(BLINK_HALF_CYCLES)
    ) u_blink (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .blinkBus(blinkBus.gen)
    );

    logic anyLink;
    logic activity;
    logic reducedOn;
    logic combined;
    logic [PLA_NUM_LEDS-1:0] liveStatus;
    logic [PLA_NUM_LEDS-1:0] ledLevel;

    // Indicator order, low to high: duplex, link1000, link100, link10, activity.
    assign anyLink = link10 | link100 | link1000;
    assign activity = txActive | rxActive | idleError;
    assign reducedOn = st.ledCtrl[PLA_LED_REDUCED_BIT];
    // Link only when the select is set, otherwise link lamp that blinks on traffic.
    assign combined = st.rledSel ? anyLink :
        (anyLink & (activity ? blinkBus.blink : 1'b1));

    assign liveStatus[0] = anyLink & fullDuplex;
    assign liveStatus[1] = link1000;
    assign liveStatus[2] = link100;
    assign liveStatus[3] = reducedOn ? combined : link10;
    assign liveStatus[4] = activity;

    for (genvar i = 0; i < PLA_NUM_LEDS; i++) begin : g_led
        pla_mode_t mode;
        assign mode = pla_mode_t'(st.ledCtrl[PLA_LED_FIELD_LSB + 2 * i +: 2]);
        always_comb begin
            unique case (mode)
                PLA_MODE_NORMAL: ledLevel[i] = liveStatus[i];
                PLA_MODE_OFF: ledLevel[i] = 1'b0;
                PLA_MODE_BLINK: ledLevel[i] = blinkBus.blink;
                PLA_MODE_ON: ledLevel[i] = 1'b1;
            endcase
        end
    end

    always_comb begin
        next_st = st;
        next_st.rdValid = mgmtRdEn;
        if (mgmtWrEn) begin
            unique case (mgmtAddr)
                PLA_ADDR_AUX: begin
                    next_st.loopOn = mgmtWrData[PLA_AUX_LOOP_BIT];
                    next_st.revOn = mgmtWrData[PLA_AUX_REV_BIT];
                    next_st.jabDis = mgmtWrData[PLA_AUX_JAB_BIT];
                end
                PLA_ADDR_LED: begin
                    next_st.ledCtrl = mgmtWrData;
                end
                PLA_ADDR_REDUCED_INDICATOR_MODE_SEL: begin
                    next_st.rledSel = mgmtWrData[PLA_REDUCED_INDICATOR_MODE_SEL_BIT];
                end
                default: begin
                end
            endcase
        end
        if (mgmtRdEn) begin
            next_st.rdData = '0;
            unique case (mgmtAddr)
                PLA_ADDR_STATUS: begin
                    next_st.rdData[PLA_STATUS_LOOP_BIT] = st.loopOn;
                end
                PLA_ADDR_AUX: begin
                    // Reserved bits 3:1 and unbuilt upper bits stay zero.
                    next_st.rdData[PLA_AUX_LOOP_BIT] = st.loopOn;
                    next_st.rdData[PLA_AUX_REV_BIT] = st.revOn;
                    next_st.rdData[PLA_AUX_JAB_BIT] = st.jabDis;
                end
                PLA_ADDR_LED: begin
                    next_st.rdData = st.ledCtrl;
                end
                PLA_ADDR_REDUCED_INDICATOR_MODE_SEL: begin
                    next_st.rdData[PLA_REDUCED_INDICATOR_MODE_SEL_BIT] = st.rledSel;
                end
                default: begin
                end
            endcase
        end

        // Loopback skips both reversals, since they would cancel anyway.
        if (st.loopOn) begin
            next_st.rxd = macTxd;
            next_st.rxDv = macTxEn;
            next_st.rxEr = macTxEr;
            next_st.txd = '0;
            next_st.txEn = 1'b0;
            next_st.txEr = 1'b0;
        end else begin
            next_st.rxd = st.revOn ? pla_rev8(lineRxd) : lineRxd;
            next_st.rxDv = lineRxDv;
            next_st.rxEr = lineRxEr;
            next_st.txd = st.revOn ? pla_rev8(macTxd) : macTxd;
            next_st.txEn = macTxEn;
            next_st.txEr = macTxEr;
        end

        next_st.jabber = jabberDetect & ~(st.jabDis & mode10);
        next_st.led = ledLevel;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.loopOn <= PLA_AUX_BIT_RESET;
            st.revOn <= PLA_AUX_BIT_RESET;
            st.jabDis <= PLA_AUX_BIT_RESET;
            st.ledCtrl <= PLA_LED_RESET;
            st.rledSel <= PLA_REDUCED_INDICATOR_MODE_SEL_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign mgmtRdData = st.rdData;
    assign mgmtRdValid = st.rdValid;
    assign macRxd = st.rxd;
    assign macRxDv = st.rxDv;
    assign macRxEr = st.rxEr;
    assign lineTxd = st.txd;
    assign lineTxEn = st.txEn;
    assign lineTxEr = st.txEr;
    assign jabberActive = st.jabber;
    assign ledDuplex = st.led[0];
    assign ledLink1000 = st.led[1];
    assign ledLink100 = st.led[2];
    assign ledLink10 = st.led[3];
    assign ledAct = st.led[4];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    chk_loop_rx_data: assert property (
        st.loopOn |=> (macRxDv == $past(macTxEn) && macRxd == $past(macTxd)))
        else $error("Looped frame did not appear on the receive outputs.");

    chk_loop_no_line: assert property (
        st.loopOn |=> (!lineTxEn && !lineTxEr))
        else $error("Line transmit active during MAC loopback.");

    chk_status_loop_bit: assert property (
        (mgmtRdEn && mgmtAddr == PLA_ADDR_STATUS)
        |=> (mgmtRdValid && mgmtRdData[PLA_STATUS_LOOP_BIT] == $past(st.loopOn)))
        else $error("Status loopback bit does not match loopback state.");

    chk_rev_tx_order: assert property (
        (st.revOn && !st.loopOn) |=> (lineTxd == pla_rev8($past(macTxd))))
        else $error("Transmit data not bit reversed.");

    chk_jabber_ignored: assert property (
        (st.jabDis && mode10) |=> !jabberActive)
        else $error("Jabber reported while disabled in 10 Mb/s.");

    chk_aux_reserved_zero: assert property (
        (mgmtRdEn && mgmtAddr == PLA_ADDR_AUX) |=> (mgmtRdData[3:1] == 3'h0))
        else $error("Reserved auxiliary bits read as nonzero.");

    chk_act_forced: assert property (
        (st.ledCtrl[15:14] == 2'h1 && $stable(st.ledCtrl)) |=> !ledAct ##0
        ($past(st.ledCtrl[15:14]) == 2'h1))
        else $error("Activity indicator lit while forced off.");

    chk_act_blink: assert property (
        (st.ledCtrl[15:14] == 2'h2) |=> (ledAct == $past(blinkBus.blink)))
        else $error("Activity indicator does not follow the blink level.");

    chk_link10_live: assert property (
        (st.ledCtrl[13:12] == 2'h0 && !reducedOn) |=> (ledLink10 == $past(link10)))
        else $error("10 Mb/s link indicator does not follow link state.");

    chk_reduced_link: assert property (
        (st.ledCtrl[13:12] == 2'h0 && reducedOn && st.rledSel)
        |=> (ledLink10 == $past(anyLink)))
        else $error("Reduced indicator does not show link at any speed.");

    chk_duplex_forced_on: assert property (
        (st.ledCtrl[7:6] == 2'h3) |=> ledDuplex)
        else $error("Duplex indicator dark while forced on.");

    chk_loop_rx_err: assert property (
        st.loopOn |=> (macRxEr == $past(macTxEr)))
        else $error("Looped error flag did not appear on the receive outputs.");

    chk_loop_no_txd: assert property (
        st.loopOn |=> (lineTxd == 8'h00))
        else $error("Line transmit data nonzero during MAC loopback.");

    chk_rev_rx_order: assert property (
        (st.revOn && !st.loopOn) |=> (macRxd == pla_rev8($past(lineRxd))))
        else $error("Receive data not bit reversed.");

    chk_fwd_tx_order: assert property (
        (!st.revOn && !st.loopOn) |=> (lineTxd == $past(macTxd)))
        else $error("Transmit data altered while reversal is off.");

    chk_fwd_rx_order: assert property (
        (!st.revOn && !st.loopOn) |=> (macRxd == $past(lineRxd)))
        else $error("Receive data altered while reversal is off.");

    chk_jabber_passed: assert property (
        !(st.jabDis && mode10) |=> (jabberActive == $past(jabberDetect)))
        else $error("Jabber level lost while jabber handling is enabled.");

    chk_act_live: assert property (
        (st.ledCtrl[15:14] == 2'h0) |=> (ledAct == $past(txActive | rxActive | idleError)))
        else $error("Activity indicator does not follow traffic.");

    chk_act_forced_on: assert property (
        (st.ledCtrl[15:14] == 2'h3) |=> ledAct)
        else $error("Activity indicator dark while forced on.");

    chk_link10_off: assert property (
        (st.ledCtrl[13:12] == 2'h1) |=> !ledLink10)
        else $error("10 Mb/s link indicator lit while forced off.");

    chk_link100_live: assert property (
        (st.ledCtrl[11:10] == 2'h0) |=> (ledLink100 == $past(link100)))
        else $error("100 Mb/s link indicator does not follow link state.");

    chk_link1000_live: assert property (
        (st.ledCtrl[9:8] == 2'h0) |=> (ledLink1000 == $past(link1000)))
        else $error("Gigabit link indicator does not follow link state.");

    chk_duplex_live: assert property (
        (st.ledCtrl[7:6] == 2'h0)
        |=> (ledDuplex == $past(fullDuplex && (link10 || link100 || link1000))))
        else $error("Duplex indicator does not follow the duplex state.");

    chk_duplex_blink: assert property (
        (st.ledCtrl[7:6] == 2'h2) |=> (ledDuplex == $past(blinkBus.blink)))
        else $error("Duplex indicator does not follow the blink level.");

    chk_reduced_combined: assert property (
        (st.ledCtrl[13:12] == 2'h0 && reducedOn && !st.rledSel)
        |=> (ledLink10 == $past(anyLink && (!activity || blinkBus.blink))))
        else $error("Combined indicator wrong in link plus activity selection.");

    chk_led_ctrl_write: assert property (
        (mgmtWrEn && mgmtAddr == PLA_ADDR_LED) |=> (st.ledCtrl == $past(mgmtWrData)))
        else $error("Indicator control write did not land.");
endmodule : pla_led_aux_top

// file: dv/pla_line_model.sv
`timescale 1ns/1ps
module pla_line_model (
    input wire logic clk_sys,
    input wire logic sendLine,
    input wire pla_pkg::pla_byte_t sendByte,
    output pla_pkg::pla_byte_t lineRxd,
    output logic lineRxDv,
    output logic lineRxEr
);
    import pla_pkg::*;
    pla_byte_t rxd = 8'h5a;
    logic rxDv = 1'b0;
    // An idle line keeps changing its data so stale bytes never look valid.
    always @(posedge clk_sys) begin
        if (sendLine) begin
            rxd <= sendByte;
            rxDv <= 1'b1;
        end else begin
            rxd <= ~rxd;
            rxDv <= 1'b0;
        end
    end
    assign lineRxd = rxd;
    assign lineRxDv = rxDv;
    assign lineRxEr = 1'b0;
endmodule : pla_line_model

// file: dv/test_phy_led_and_aux_control.sv
`timescale 1ns/1ps
module test_phy_led_and_aux_control;
    import pla_pkg::*;
    localparam int HALF = 8;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    pla_addr_t mgmtAddr = 5'h00;
    pla_word_t mgmtWrData = 16'h0000;
    logic mgmtWrEn = 1'b0;
    logic mgmtRdEn = 1'b0;
    pla_byte_t macTxd = 8'h00;
    logic macTxEn = 1'b0;
    logic macTxEr = 1'b0;
    logic jabberDetect = 1'b0;
    logic mode10 = 1'b0;
    logic link10 = 1'b0;
    logic link100 = 1'b0;
    logic link1000 = 1'b0;
    logic fullDuplex = 1'b0;
    logic txActive = 1'b0;
    logic rxActive = 1'b0;
    logic idleError = 1'b0;
    logic sendLine = 1'b0;
    pla_byte_t sendByte = 8'h00;
    logic [15:0] mgmtRdData;
    logic [7:0] macRxd, lineTxd;
    pla_byte_t lineRxd;
    logic mgmtRdValid, macRxDv, macRxEr, lineTxEn, lineTxEr, lineRxDv, lineRxEr, jabberActive;
    logic ledAct, ledLink10, ledLink100, ledLink1000, ledDuplex;
    int fails = 0;
    int n_checks = 0;

    always #20 clk_sys = ~clk_sys;

    pla_led_aux_top #(.BLINK_HALF_CYCLES(HALF)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b),
        .mgmtAddr(mgmtAddr), .mgmtWrData(mgmtWrData), .mgmtWrEn(mgmtWrEn),
        .mgmtRdEn(mgmtRdEn), .mgmtRdData(mgmtRdData), .mgmtRdValid(mgmtRdValid),
        .macTxd(macTxd), .macTxEn(macTxEn), .macTxEr(macTxEr), .macRxd(macRxd),
        .macRxDv(macRxDv), .macRxEr(macRxEr), .lineTxd(lineTxd), .lineTxEn(lineTxEn),
        .lineTxEr(lineTxEr), .lineRxd(lineRxd), .lineRxDv(lineRxDv), .lineRxEr(lineRxEr),
        .jabberDetect(jabberDetect), .mode10(mode10), .jabberActive(jabberActive),
        .link10(link10), .link100(link100), .link1000(link1000), .fullDuplex(fullDuplex),
        .txActive(txActive), .rxActive(rxActive), .idleError(idleError), .ledAct(ledAct),
        .ledLink10(ledLink10), .ledLink100(ledLink100), .ledLink1000(ledLink1000),
        .ledDuplex(ledDuplex));

    pla_line_model line_u (.clk_sys(clk_sys), .sendLine(sendLine), .sendByte(sendByte),
        .lineRxd(lineRxd), .lineRxDv(lineRxDv), .lineRxEr(lineRxEr));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input pla_addr_t a, input pla_word_t d);
        mgmtAddr = a;
        mgmtWrData = d;
        mgmtWrEn = 1'b1;
        cyc(1);
        mgmtWrEn = 1'b0;
        cyc(1);
    endtask : wr

    // A read without its valid pulse comes back unknown so the caller's compare fails.
    task automatic rd(input pla_addr_t a, output logic [15:0] d);
        mgmtAddr = a;
        mgmtRdEn = 1'b1;
        cyc(1);
        mgmtRdEn = 1'b0;
        d = (mgmtRdValid === 1'b1) ? mgmtRdData : 16'hxxxx;
        cyc(1);
    endtask : rd

    function automatic logic pick(input int sel);
        return (sel == 0) ? ledAct : ledLink10;
    endfunction : pick

    // The first pass finds an edge, the second measures the level's length.
    task automatic halfPeriod(input int sel, output int n);
        logic prev;
        for (int k = 0; k < 2; k++) begin
            prev = pick(sel);
            n = 0;
            while (pick(sel) === prev && n < 40) begin
                cyc(1);
                n++;
            end
            if (n >= 40) begin
                fails++;
                $display("mismatch at %0t: indicator stopped blinking", $time);
                wrap_up();
            end
        end
    endtask : halfPeriod

    task automatic t_regs;
        logic [15:0] d;
        rd(PLA_ADDR_LED, d);
        chk(d, 16'h0000);
        wr(PLA_ADDR_LED, 16'h001f);
        rd(PLA_ADDR_LED, d);
        chk(d, 16'h001f);
        wr(PLA_ADDR_LED, 16'h0000);
        wr(5'h1f, 16'hffff);
        rd(5'h1f, d);
        chk(d, 16'h0000);
        wr(PLA_ADDR_AUX, 16'h0031);
        rd(PLA_ADDR_AUX, d);
        chk(d, 16'h0031);
        rd(PLA_ADDR_STATUS, d);
        chk(d, 16'h0080);
        macTxEn = 1'b1;
        macTxEr = 1'b1;
        macTxd = 8'h83;
        sendLine = 1'b1;
        sendByte = 8'h55;
        cyc(2);
        chk({6'h00, macRxDv, macRxEr, macRxd}, 16'h0383);
        chk({6'h00, lineTxEn, lineTxEr, lineTxd}, 16'h0000);
        macTxEr = 1'b0;
        sendByte = 8'h0d;
        wr(PLA_ADDR_AUX, 16'h0010);
        chk({7'h00, lineTxEn, lineTxd}, 16'h01c1);
        chk({7'h00, macRxDv, macRxd}, 16'h01b0);
        wr(PLA_ADDR_AUX, 16'h0000);
        chk({7'h00, lineTxEn, lineTxd}, 16'h0183);
        rd(PLA_ADDR_STATUS, d);
        chk(d, 16'h0000);
        macTxEn = 1'b0;
        sendLine = 1'b0;
    endtask : t_regs

    task automatic t_jabber;
        jabberDetect = 1'b1;
        mode10 = 1'b1;
        cyc(1);
        chk(jabberActive, 1'b1);
        wr(PLA_ADDR_AUX, 16'h0001);
        chk(jabberActive, 1'b0);
        mode10 = 1'b0;
        cyc(1);
        chk(jabberActive, 1'b1);
        wr(PLA_ADDR_AUX, 16'h0000);
        jabberDetect = 1'b0;
    endtask : t_jabber

    task automatic t_leds;
        logic [6:0] st[5] = '{7'h28, 7'h40, 7'h14, 7'h0a, 7'h49};
        logic [4:0] ex[5] = '{5'h05, 5'h08, 5'h12, 5'h10, 5'h19};
        logic [1:0] m;
        int n;
        for (int i = 0; i < 5; i++) begin
            {link10, link100, link1000, fullDuplex, txActive, rxActive, idleError} = st[i];
            cyc(1);
            chk({ledAct, ledLink10, ledLink100, ledLink1000, ledDuplex}, ex[i]);
        end
        for (int c = 0; c < 4; c++) begin
            m = c[1:0];
            wr(PLA_ADDR_LED, {m, m, m, m, m, 6'h00});
            case (m)
                2'h0: chk({ledAct, ledLink10, ledLink100, ledLink1000, ledDuplex}, 5'h19);
                2'h1: chk({ledAct, ledLink10, ledLink100, ledLink1000, ledDuplex}, 5'h00);
                2'h3: chk({ledAct, ledLink10, ledLink100, ledLink1000, ledDuplex}, 5'h1f);
                default: begin
                    halfPeriod(0, n);
                    chk(n, HALF);
                    chk({ledLink10, ledLink100, ledLink1000, ledDuplex}, {4{ledAct}});
                end
            endcase
        end
        wr(PLA_ADDR_LED, 16'h0000);
    endtask : t_leds

    task automatic t_reduced;
        logic [15:0] d;
        int n;
        {link10, link100, link1000, fullDuplex, txActive, rxActive, idleError} = 7'h22;
        wr(PLA_ADDR_REDUCED_INDICATOR_MODE_SEL, 16'h0001);
        wr(PLA_ADDR_LED, 16'h0020);
        for (int k = 0; k < 2 * HALF; k++) begin
            cyc(1);
            chk(ledLink10, 1'b1);
        end
        wr(PLA_ADDR_REDUCED_INDICATOR_MODE_SEL, 16'h0000);
        halfPeriod(1, n);
        chk(n, HALF);
        rxActive = 1'b0;
        cyc(1);
        chk(ledLink10, 1'b1);
        link100 = 1'b0;
        cyc(1);
        chk(ledLink10, 1'b0);
        rd(PLA_ADDR_REDUCED_INDICATOR_MODE_SEL, d);
        chk(d, 16'h0000);
        wr(PLA_ADDR_LED, 16'h0000);
    endtask : t_reduced

    initial begin
        repeat (12) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        cyc(1);
        t_regs();
        t_jabber();
        t_leds();
        t_reduced();
        wrap_up();
    end
endmodule : test_phy_led_and_aux_control
